// ==== core/trip_logic.sv ====
// protection and trip handling: output block, trip reset, option fault,
// missing motor, latched undervoltage, replacement status
// assumes synchronous inputs on I_CLK and an active-high synchronous reset
// Contract
// R01 - block input code 5 blocks output immediately
// R02 - restart needs input released and new run
// R03 - hold frequency and current snapshot at block
// R04 - seven terminals each with selector 0-54
// R05 - reset-function terminal clears trip status
// R06 - keypad stop/reset key also clears trip
// R07 - replacement status: 00 none, 01 cap, 10 fan
// R08 - option comm fail or removal is fault
// R09 - option action 0 none, 1 block and trip
// R10 - option action 2 decelerates with fault time
// R11 - missing-motor action selector, default none
// R12 - low current for detection time trips
// R13 - latched undervoltage held until reset
// R14 - latched undervoltage not written to history
// R15 - undervoltage stops output and raises trip
// R16 - requests within one cycle, trips latch (code: plain-mode undervoltage clears with I_DC_LOW)
module trip_logic #(
  parameter int unsigned TENTH_CYC = trip_pkg::TENTH_S_CYC
) (
  input  wire logic                         I_CLK,
  input  wire logic                         I_RST,
  input  wire logic [trip_pkg::N_TERM-1:0]  I_TERM,
  input  wire logic [41:0]                  I_TERM_FUNC,
  input  wire logic                         I_RUN_CMD,
  input  wire logic                         I_KEY_STOP_RESET,
  input  wire logic [15:0]                  I_OUT_FREQ,
  input  wire logic [15:0]                  I_OUT_CURR,
  input  wire logic [6:0]                   I_CURR_PCT,
  input  wire logic                         I_OPT_COMM_FAIL,
  input  wire logic                         I_OPT_REMOVED,
  input  wire logic [1:0]                   I_OPT_ACTION,
  input  wire logic                         I_NM_ENABLE,
  input  wire logic [6:0]                   I_NM_LEVEL,
  input  wire logic [6:0]                   I_NM_TIME,
  input  wire logic                         I_DC_LOW,
  input  wire logic                         I_UV_LATCH_SEL,
  input  wire logic                         I_CAP_WARN,
  input  wire logic                         I_FAN_WARN,
  output logic                              O_OUT_BLOCK,
  output logic                              O_DECEL,
  output logic                              O_BLOCK_SHOWN,
  output logic [15:0]                       O_SNAP_FREQ,
  output logic [15:0]                       O_SNAP_CURR,
  output logic                              O_OPT_TRIP,
  output logic                              O_NM_TRIP,
  output logic                              O_UV_TRIP,
  output logic                              O_HIST_WRITE,
  output logic [1:0]                        O_REPL_STATUS,
  output logic [6:0]                        O_FUNC_ERR
);
  import trip_pkg::*;

  typedef struct packed {
    blk_st_t     blk;
    logic [15:0] snap_f;
    logic [15:0] snap_c;
    logic        opt_trip;
    logic        opt_dec;
    logic        nm_trip;
    logic        uv_trip;
    logic        hist;
    logic [23:0] tick;
    logic [6:0]  tenths;
    logic [1:0]  repl;
  } state_t;

  state_t s_r, s_nxt;

  // ==========================================================
  // terminal decode
  logic [N_TERM-1:0] blk_hit, rst_hit, bad_code;
  genvar g;
  generate
    for (g = 0; g < N_TERM; g++) begin : g_term
      wire [5:0] fn = I_TERM_FUNC[g*6 +: 6];
      assign bad_code[g] = fn > FN_MAX;                 // see R04
      assign blk_hit[g]  = I_TERM[g] && fn == FN_BLK;   // see R01
      assign rst_hit[g]  = I_TERM[g] && fn == FN_RST;   // see R05
    end
  endgenerate

  wire blk_in    = |blk_hit;
  wire reset_req = (|rst_hit) | I_KEY_STOP_RESET;       // see R06
  wire opt_fault = I_OPT_COMM_FAIL | I_OPT_REMOVED;     // see R08
  wire [6:0] nm_time = (I_NM_TIME < NM_TIME_MIN) ? NM_TIME_MIN :
                       (I_NM_TIME > NM_TIME_MAX) ? NM_TIME_MAX : I_NM_TIME;
  wire [6:0] nm_lvl  = (I_NM_LEVEL < NM_LEVEL_MIN) ? NM_LEVEL_MIN :
                       (I_NM_LEVEL > NM_LEVEL_MAX) ? NM_LEVEL_MAX : I_NM_LEVEL;
  wire low_curr  = I_RUN_CMD && I_CURR_PCT < nm_lvl;

  // ==========================================================
  always_comb begin
    s_nxt      = s_r;
    s_nxt.hist = 1'b0;
    // output block state; restart only after release and a fresh run
    case (s_r.blk)
      ST_RUN: begin
        if (blk_in) begin
          s_nxt.blk    = ST_BLK;                        // see R01
          s_nxt.snap_f = I_OUT_FREQ;                    // see R03
          s_nxt.snap_c = I_OUT_CURR;
        end
      end
      ST_BLK: begin
        if (!blk_in) s_nxt.blk = ST_WAIT;               // see R02
      end
      ST_WAIT: begin
        // a fresh block while waiting takes a new snapshot as well
        if (blk_in) begin
          s_nxt.blk    = ST_BLK;                        // see R01
          s_nxt.snap_f = I_OUT_FREQ;                    // see R03
          s_nxt.snap_c = I_OUT_CURR;
        end else if (!I_RUN_CMD) begin
          s_nxt.blk = ST_RUN;                           // see R02
        end
      end
      default: s_nxt.blk = ST_RUN;
    endcase
    // reset clears first so that a new event in the same cycle wins
    if (reset_req) begin
      s_nxt.opt_trip = 1'b0;
      s_nxt.opt_dec  = 1'b0;
      s_nxt.nm_trip  = 1'b0;
      s_nxt.uv_trip  = 1'b0;
    end
    if (opt_fault && I_OPT_ACTION == OPT_FREE) s_nxt.opt_trip = 1'b1; // see R09
    if (opt_fault && I_OPT_ACTION == OPT_DEC)  s_nxt.opt_dec  = 1'b1; // see R10
    // missing-motor timer in tenths of a second
    if (I_NM_ENABLE && low_curr && !s_r.nm_trip) begin                // see R11
      if (s_r.tick >= 24'(TENTH_CYC - 1)) begin
        s_nxt.tick   = '0;
        s_nxt.tenths = s_r.tenths + 7'h01;
        if (s_r.tenths + 7'h01 >= nm_time) begin
          s_nxt.nm_trip = 1'b1;                         // see R12
          s_nxt.hist    = 1'b1;
        end
      end else begin
        s_nxt.tick = s_r.tick + 24'h000001;
      end
    end else begin
      s_nxt.tick   = '0;
      s_nxt.tenths = '0;
    end
    // undervoltage: latched mode ignores recovery, plain mode follows the rail
    if (I_DC_LOW) begin
      s_nxt.uv_trip = 1'b1;                             // see R15
      if (!s_r.uv_trip && !I_UV_LATCH_SEL) s_nxt.hist = 1'b1; // see R14
    end else if (!I_UV_LATCH_SEL) begin                 // see R13
      s_nxt.uv_trip = 1'b0;
    end
    // action 3 acts as none, so it must not log a trip
    if (opt_fault && (I_OPT_ACTION == OPT_FREE || I_OPT_ACTION == OPT_DEC) && !s_r.opt_trip && !s_r.opt_dec) begin
      s_nxt.hist = 1'b1;
    end
    // replacement status, capacitor reported ahead of fan
    s_nxt.repl = I_CAP_WARN ? REPL_CAP : (I_FAN_WARN ? REPL_FAN : REPL_NONE); // see R07
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      s_r <= '{blk: ST_RUN, snap_f: 16'h0000, snap_c: 16'h0000, opt_trip: 1'b0, opt_dec: 1'b0,
               nm_trip: 1'b0, uv_trip: 1'b0, hist: 1'b0, tick: 24'h000000, tenths: 7'h00,
               repl: REPL_NONE};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // block is combinational on the live input so it acts the same cycle
  assign O_OUT_BLOCK   = blk_in || s_r.blk != ST_RUN || s_r.opt_trip
                         || s_r.nm_trip || s_r.uv_trip;           // see R16
  assign O_DECEL       = s_r.opt_dec && !O_OUT_BLOCK;             // see R16
  assign O_BLOCK_SHOWN = s_r.blk == ST_BLK;
  assign O_SNAP_FREQ   = s_r.snap_f;
  assign O_SNAP_CURR   = s_r.snap_c;
  assign O_OPT_TRIP    = s_r.opt_trip;
  assign O_NM_TRIP     = s_r.nm_trip;
  assign O_UV_TRIP     = s_r.uv_trip;
  assign O_HIST_WRITE  = s_r.hist;
  assign O_REPL_STATUS = s_r.repl;
  assign O_FUNC_ERR    = bad_code;

  // ==========================================================
  // checks
  sequence s_blk_rise;
    $rose(blk_in) && s_r.blk != ST_BLK;
  endsequence
  sequence s_snap_held;
    O_SNAP_FREQ == $past(I_OUT_FREQ) && O_SNAP_CURR == $past(I_OUT_CURR);
  endsequence

  property p_blk_now;
    @(posedge I_CLK) disable iff (I_RST) blk_in |-> O_OUT_BLOCK ##1 O_BLOCK_SHOWN;
  endproperty
  a_blk_now: assert property (p_blk_now) else $error("block input did not block output"); // see R01

  property p_no_early_restart;
    @(posedge I_CLK) disable iff (I_RST)
      (s_r.blk == ST_WAIT && I_RUN_CMD && !blk_in) |=> O_OUT_BLOCK;
  endproperty
  a_no_early_restart: assert property (p_no_early_restart) else $error("restart without new run"); // see R02

  property p_snap;
    @(posedge I_CLK) disable iff (I_RST) s_blk_rise |=> s_snap_held;
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot not captured"); // see R03

  property p_reset_clears;
    @(posedge I_CLK) disable iff (I_RST)
      (reset_req && !opt_fault && !I_DC_LOW && !(I_NM_ENABLE && low_curr)) |=> !O_OPT_TRIP && !O_UV_TRIP && !O_NM_TRIP;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear trip"); // see R05

  property p_opt_free;
    @(posedge I_CLK) disable iff (I_RST) (opt_fault && I_OPT_ACTION == OPT_FREE) |=> O_OPT_TRIP && O_OUT_BLOCK;
  endproperty
  a_opt_free: assert property (p_opt_free) else $error("option fault did not block"); // see R09

  property p_opt_dec;
    @(posedge I_CLK) disable iff (I_RST) (opt_fault && I_OPT_ACTION == OPT_DEC) |=> s_r.opt_dec;
  endproperty
  a_opt_dec: assert property (p_opt_dec) else $error("option fault did not decelerate"); // see R10

  property p_nm_off;
    @(posedge I_CLK) disable iff (I_RST) !$past(I_NM_ENABLE) |-> !$rose(O_NM_TRIP);
  endproperty
  a_nm_off: assert property (p_nm_off) else $error("missing-motor trip while disabled"); // see R11

  property p_uv_latched;
    @(posedge I_CLK) disable iff (I_RST) (O_UV_TRIP && I_UV_LATCH_SEL && !reset_req) |=> O_UV_TRIP;
  endproperty
  a_uv_latched: assert property (p_uv_latched) else $error("latched undervoltage dropped"); // see R13

  property p_uv_no_hist;
    @(posedge I_CLK) disable iff (I_RST)
      (I_DC_LOW && I_UV_LATCH_SEL && !opt_fault && !I_NM_ENABLE) |=> !O_HIST_WRITE;
  endproperty
  a_uv_no_hist: assert property (p_uv_no_hist) else $error("latched undervoltage logged"); // see R14

  property p_uv_trip;
    @(posedge I_CLK) disable iff (I_RST) I_DC_LOW |=> O_UV_TRIP ##0 O_OUT_BLOCK;
  endproperty
  a_uv_trip: assert property (p_uv_trip) else $error("undervoltage not tripped"); // see R15
endmodule

// ==== core/trip_pkg.sv ====
// constants and types shared by the protection and trip logic
// assumes one 10 MHz control clock and synchronous inputs
package trip_pkg;
  // ==========================================================
  // terminal function codes
  localparam int unsigned N_TERM = 7;
  localparam logic [5:0] FN_MAX = 6'h36;  // highest accepted code (54)
  localparam logic [5:0] FN_RST = 6'h03;  // trip reset
  localparam logic [5:0] FN_BLK = 6'h05;  // output block
  // ==========================================================
  // option fault actions
  localparam logic [1:0] OPT_NONE = 2'h0;
  localparam logic [1:0] OPT_FREE = 2'h1;
  localparam logic [1:0] OPT_DEC  = 2'h2;
  // ==========================================================
  // replacement status codes
  localparam logic [1:0] REPL_NONE = 2'h0;
  localparam logic [1:0] REPL_CAP  = 2'h1;
  localparam logic [1:0] REPL_FAN  = 2'h2;
  // ==========================================================
  // missing-motor timing: detection time in tenths of a second
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TENTH_S_CYC   = CLK_HZ / 10;
  localparam logic [6:0]  NM_LEVEL_RST  = 7'h05;   // percent
  localparam logic [6:0]  NM_TIME_RST   = 7'h1e;   // 3.0 s
  localparam logic [6:0]  NM_TIME_MIN   = 7'h01;   // 0.1 s
  localparam logic [6:0]  NM_TIME_MAX   = 7'h64;   // 10 s
  localparam logic [6:0]  NM_LEVEL_MIN  = 7'h01;
  localparam logic [6:0]  NM_LEVEL_MAX  = 7'h64;
  // ==========================================================
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_BLK  = 3'b010,
    ST_WAIT = 3'b100
  } blk_st_t;
endpackage

// ==== verif/drive_stage_model.sv ====
// power stage and current sensing side of the trip logic
// assumes one clock; updates land just after the rising edge
module drive_stage_model (
  input  wire logic        i_clk,
  input  wire logic        i_run,
  input  wire logic        i_block,
  input  wire logic        i_motor_on,
  output logic [15:0]      o_freq,
  output logic [15:0]      o_curr,
  output logic [6:0]       o_pct
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // load
  initial begin
    o_freq = 16'h0000;
    o_curr = 16'h0000;
    o_pct  = 7'h00;
  end
  // open motor leads leave only a trickle of current
  always @(posedge i_clk) begin
    if (i_run && !i_block) begin
      o_freq <= o_freq + 16'h0003;
    end
    o_curr <= i_motor_on ? 16'h0100 + 16'($urandom_range(255)) : 16'h0003;
    o_pct  <= i_motor_on ? 7'h28 : 7'h02;
  end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the trip logic
// assumes trip_logic with a short tenth-second count
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import trip_pkg::*;
  // ==========================================================
  // signals
  logic        clk, rst, run, key, cf, cr, ne, dl, us, cw, fw, mo;
  logic [6:0]  term, nl, nt, pct, fe;
  logic [41:0] fn;
  logic [1:0]  act, repl;
  logic [15:0] fq, cu, sf, sc, ef, ec;
  logic        blk, dec, shn, ot, nmt, uvt, hw;
  int          err_total = 0;
  int          compares  = 0;
  int          hn        = 0;
  int          h, k, n;
  drive_stage_model model (.i_clk(clk), .i_run(run), .i_block(blk), .i_motor_on(mo),
    .o_freq(fq), .o_curr(cu), .o_pct(pct));
  trip_logic #(.TENTH_CYC(4)) dut (.I_CLK(clk), .I_RST(rst), .I_TERM(term), .I_TERM_FUNC(fn),
    .I_RUN_CMD(run), .I_KEY_STOP_RESET(key), .I_OUT_FREQ(fq), .I_OUT_CURR(cu), .I_CURR_PCT(pct),
    .I_OPT_COMM_FAIL(cf), .I_OPT_REMOVED(cr), .I_OPT_ACTION(act), .I_NM_ENABLE(ne),
    .I_NM_LEVEL(nl), .I_NM_TIME(nt), .I_DC_LOW(dl), .I_UV_LATCH_SEL(us), .I_CAP_WARN(cw),
    .I_FAN_WARN(fw), .O_OUT_BLOCK(blk), .O_DECEL(dec), .O_BLOCK_SHOWN(shn), .O_SNAP_FREQ(sf),
    .O_SNAP_CURR(sc), .O_OPT_TRIP(ot), .O_NM_TRIP(nmt), .O_UV_TRIP(uvt), .O_HIST_WRITE(hw),
    .O_REPL_STATUS(repl), .O_FUNC_ERR(fe));
  // ==========================================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (hw === 1'b1) hn++;
  function automatic logic [1:0] exp_repl(input logic c, input logic f);
    return c ? REPL_CAP : (f ? REPL_FAN : REPL_NONE);
  endfunction
  task automatic step(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic key_reset;
    key = 1'b1;
    step(1);
    key = 1'b0;
    step(1);
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial begin
    {term, fn, run, key, cf, cr, act, ne, dl, us, cw, fw} = '0;
    nl = 7'h01;
    nt = NM_TIME_MIN;
    mo = 1'b1;
    rst = 1'b1;
    void'($urandom(5));
    step(2);
    rst = 1'b0;
    chk({ot, nmt, uvt, shn, repl}, 16'h0000);
    run = 1'b1;
    step(3);
    for (int i = 0; i < 3; i++) begin
      k = $urandom_range(6);
      fn = '0;
      fn[6*k +: 6] = FN_BLK;
      ef = fq;
      ec = cu;
      term[k] = 1'b1;
      #1;
      chk(blk, 1);
      step(3);
      chk(shn, 1);
      chk(sf, ef);
      chk(sc, ec);
      term[k] = 1'b0;
      step(3);
      chk(blk, 1);
      run = 1'b0;
      step(2);
      chk(blk, 0);
      run = 1'b1;
      step(2);
    end
    fn = {7{FN_MAX}};
    fn[6*k +: 6] = 6'($urandom_range(63, 55));
    term[k] = 1'b1;
    #1;
    chk(fe, 7'h01 << k);
    step(2);
    chk(blk, 0);
    term[k] = 1'b0;
    for (int a = 0; a < 4; a++) begin
      act = 2'(a);
      h = hn;
      cf = (a % 2 == 1);
      cr = (a % 2 == 0);
      step(1);
      chk({ot, blk, dec}, {a == 1, a == 1, a == 2});
      cf = 1'b0;
      cr = 1'b0;
      step(2);
      chk({6'h00, ot, dec, 8'(hn - h)}, {6'h00, a == 1, a == 2, 8'(a == 1 || a == 2)});
      key_reset();
      chk({ot, dec, blk}, 16'h0000);
    end
    ne = 1'b1;
    mo = 1'b0;
    step(12);
    chk(nmt, 0);
    ne = 1'b0;
    nl = NM_LEVEL_RST;
    step(12);
    chk(nmt, 0);
    ne = 1'b1;
    h = hn;
    step(2);
    chk(nmt, 0);
    n = 0;
    while (nmt !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    if (nmt !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    chk(16'(n), 16'(4 * NM_TIME_MIN - 2));
    mo = 1'b1;
    step(3);
    chk({6'h00, nmt, blk, 8'(hn - h)}, 16'h0301);
    key_reset();
    chk(nmt, 0);
    h = hn;
    dl = 1'b1;
    step(1);
    chk({uvt, blk}, 2'b11);
    dl = 1'b0;
    step(2);
    chk({7'h00, uvt, 8'(hn - h)}, 16'h0001);
    us = 1'b1;
    h = hn;
    dl = 1'b1;
    step(1);
    dl = 1'b0;
    step(3);
    chk({uvt, blk}, 2'b11);
    chk(16'(hn - h), 0);
    fn[6*k +: 6] = FN_RST;
    term[k] = 1'b1;
    step(1);
    term[k] = 1'b0;
    step(1);
    chk(uvt, 0);
    for (int i = 0; i < 8; i++) begin
      {cw, fw} = (i < 4) ? 2'(i) : 2'($urandom_range(3));
      step(2);
      chk(repl, exp_repl(cw, fw));
    end
    report_and_stop();
  end
endmodule
